//--- logic/cfo_map.svh
/*
  Constants of the clock fan-out configuration block: word layout, reset values
  and pin-facing counts. Assumes inclusion by bare name from design files.
*/
// Overview of operation
// - with program mode low and serial-in low, all pairs are enabled, the first clock is routed and the control register is ignored.
// - with program mode low and serial-in high, all pairs are enabled, the second clock is routed and the control register has no effect.
// - in program mode each of the first eleven rising shift-clock edges loads serial-in into stage 10 and moves every other stage down by one.
// - a shift-clock pulse with program mode low resets the state machine, the shift register and the control register.
// - unconnected configuration pins bias the block into its default state.
// - eleven shift-clock pulses fill the shift register and the twelfth copies it into the control register.
// - the first bit shifted governs output pair nine, down to the tenth bit which governs pair zero.
// - bit 10 selects the input clock, zero for the first and one for the second.
// - the control register takes only one configuration after each reset.
`ifndef CFO_MAP_SVH
`define CFO_MAP_SVH
`define CFO_WORD_BITS     11
`define CFO_PAIRS         10
`define CFO_SEL_BIT       10
`define CFO_SHIFT_PULSES  4'hb
`define CFO_SHIFT_RESET   11'h000
`define CFO_CTRL_RESET    11'h000
`define CFO_CNT_RESET     4'h0
`define CFO_SYNC_STAGES   2
`endif

//--- logic/cfo_pkg.sv
/*
  Types of the clock fan-out configuration block.
  Assumes cfo_map.svh is on the include path.
*/
`include "cfo_map.svh"
package cfo_pkg;
  // configuration sequencer states, one-hot
  typedef enum logic [2:0]
  {
    CFO_IDLE  = 3'h1,
    CFO_SHIFT = 3'h2,
    CFO_DONE  = 3'h4
  } cfo_state_t;

  // sampled configuration pins
  typedef struct packed
  {
    logic prog;
    logic sdi;
    logic sclk;
  } cfo_pins_t;
endpackage

//--- logic/cfo_sync.sv
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes the inputs are asynchronous to clk; the first stage feeds only the second.
*/
module cfo_sync #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,      // system clock
  input  wire logic         sys_rst,  // synchronous reset, active high
  input  wire logic [W-1:0] async_in, // raw pin levels
  output logic      [W-1:0] sync_out  // levels after two flops
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // next values; reset value matches the pulled pins (clock high, others low)
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q <= RST_VAL; // idle pin levels, so release shows no false edge
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // cfo_sync

//--- logic/cfo_fanout_ctrl.sv
/*
  Configuration logic of a two-in, ten-out clock fan-out buffer: serial shift
  register, one-shot control register and the per-pair enable / input select.
  Assumes the three configuration pins come from outside the clk domain and are
  externally biased (shift clock high, serial-in and program mode low) when open.
*/
`include "cfo_map.svh"
module cfo_fanout_ctrl #(
  parameter int PAIRS = `CFO_PAIRS,
  parameter int BITS  = `CFO_WORD_BITS
) (
  input  wire logic             clk,                // system clock, 100 MHz
  input  wire logic             sys_rst,            // synchronous reset, active high
  input  wire logic             config_shift_clock, // shift clock pin
  input  wire logic             config_serial_in,   // serial data / input select pin
  input  wire logic             config_prog_mode,   // program-mode pin, high = programmable
  output logic [PAIRS-1:0]      pair_oe_n,          // per pair: low = driving, high = hi-z
  output logic                  clock_in_sel,       // 0 = clock_in_first, 1 = clock_in_second
  output logic                  ctrl_loaded,        // control register holds a configuration
  output logic [BITS-1:0]       ctrl_word           // control register contents
);
  cfo_pkg::cfo_pins_t pins_s;
  logic [2:0]         pins_raw;
  logic [2:0]         pins_sync;

  assign pins_raw = {config_prog_mode, config_serial_in, config_shift_clock};

  // shift clock bit resets high like its pulled-up pin; a low reset would fake a rise
  cfo_sync #(.W(3), .RST_VAL(3'h1)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );
  assign pins_s = cfo_pkg::cfo_pins_t'(pins_sync);

  // edge detection on the synchronised shift clock (never on the first flop)
  logic sclk_q;
  logic sclk_d;
  logic rise;

  always_comb
  begin
    sclk_d = pins_s.sclk;
  end
  // start high so the pulled-up clock pin at release is not seen as an edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sclk_q <= 1'b1;
    else
      sclk_q <= sclk_d;
  end
  assign rise = pins_s.sclk & ~sclk_q;

  // configuration sequencer, shift register and control register
  cfo_pkg::cfo_state_t state_q;
  cfo_pkg::cfo_state_t state_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic [BITS-1:0]     shreg_q;
  logic [BITS-1:0]     shreg_d;
  logic [BITS-1:0]     ctrl_q;
  logic [BITS-1:0]     ctrl_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shreg_d = shreg_q;
    ctrl_d  = ctrl_q;
    if (rise)
    begin
      if (!pins_s.prog)
      begin
        // a clock pulse in standard mode clears everything and rearms
        state_d = cfo_pkg::CFO_IDLE;
        cnt_d   = `CFO_CNT_RESET;
        shreg_d = `CFO_SHIFT_RESET;
        ctrl_d  = `CFO_CTRL_RESET;
      end
      else
      begin
        case (state_q)
          cfo_pkg::CFO_IDLE,
          cfo_pkg::CFO_SHIFT:
          begin
            if (cnt_q == `CFO_SHIFT_PULSES)
            begin
              // twelfth pulse copies the word; no further shifting after this
              ctrl_d  = shreg_q;
              state_d = cfo_pkg::CFO_DONE;
            end
            else
            begin
              // first bit shifted ends up in bit 0 after eleven pulses
              shreg_d = {pins_s.sdi, shreg_q[BITS-1:1]};
              cnt_d   = cnt_q + 4'h1;
              state_d = cfo_pkg::CFO_SHIFT;
            end
          end
          cfo_pkg::CFO_DONE:
          begin
            state_d = cfo_pkg::CFO_DONE;
          end
          default:
          begin
            state_d = cfo_pkg::CFO_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= cfo_pkg::CFO_IDLE;
      cnt_q   <= `CFO_CNT_RESET;
      shreg_q <= `CFO_SHIFT_RESET;
      ctrl_q  <= `CFO_CTRL_RESET;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shreg_q <= shreg_d;
      ctrl_q  <= ctrl_d;
    end
  end

  // output decode; the register only counts in program mode once loaded
  logic [PAIRS-1:0] oe_n_q;
  logic [PAIRS-1:0] oe_n_d;
  logic             sel_q;
  logic             sel_d;
  logic             loaded;

  assign loaded = (state_q == cfo_pkg::CFO_DONE);

  genvar g;
  generate
    for (g = 0; g < PAIRS; g++)
    begin : g_pair
      // bit 9-g enables pair g; unloaded or standard mode drives every pair
      always_comb
      begin
        if (pins_s.prog && loaded)
          oe_n_d[g] = ~ctrl_q[PAIRS-1-g];
        else
          oe_n_d[g] = 1'b0;
      end
    end
  endgenerate

  // standard mode: serial-in picks the input directly
  always_comb
  begin
    if (pins_s.prog && loaded)
      sel_d = ctrl_q[`CFO_SEL_BIT];
    else if (pins_s.prog)
      sel_d = 1'b0;
    else
      sel_d = pins_s.sdi;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      oe_n_q <= '0;
      sel_q  <= 1'b0;
    end
    else
    begin
      oe_n_q <= oe_n_d;
      sel_q  <= sel_d;
    end
  end

  assign pair_oe_n    = oe_n_q;
  assign clock_in_sel = sel_q;
  logic [2:0] state_bits;
  assign state_bits   = state_q;
  assign ctrl_loaded  = state_bits[2]; // one-hot done bit, no decode after the flop
  assign ctrl_word    = ctrl_q;

  // standard mode drives every pair whatever the control register holds
  property p_std_all_on;
    @(posedge clk) disable iff (sys_rst)
    !pins_s.prog |=> (pair_oe_n == '0);
  endproperty
  a_std_all_on: assert property (p_std_all_on) else $error("pair off in standard mode");

  property p_std_sel;
    @(posedge clk) disable iff (sys_rst)
    !pins_s.prog |=> (clock_in_sel == $past(pins_s.sdi));
  endproperty
  a_std_sel: assert property (p_std_sel) else $error("select not following serial-in");

  property p_shift;
    @(posedge clk) disable iff (sys_rst)
    (rise && pins_s.prog && state_q != cfo_pkg::CFO_DONE && cnt_q != `CFO_SHIFT_PULSES)
      |=> (shreg_q == {$past(pins_s.sdi), $past(shreg_q[BITS-1:1])});
  endproperty
  a_shift: assert property (p_shift) else $error("shift step wrong");

  property p_rearm;
    @(posedge clk) disable iff (sys_rst)
    (rise && !pins_s.prog) |=> (state_q == cfo_pkg::CFO_IDLE && ctrl_q == '0 && shreg_q == '0);
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm did not clear state");

  sequence s_twelfth;
    rise && pins_s.prog && cnt_q == `CFO_SHIFT_PULSES && state_q != cfo_pkg::CFO_DONE;
  endsequence
  property p_load;
    @(posedge clk) disable iff (sys_rst)
    s_twelfth |=> (ctrl_q == $past(shreg_q) && loaded);
  endproperty
  a_load: assert property (p_load) else $error("control register not loaded");

  property p_once;
    @(posedge clk) disable iff (sys_rst)
    (loaded && pins_s.prog) |=> $stable(ctrl_q);
  endproperty
  a_once: assert property (p_once) else $error("control register rewritten");

  property p_prog_sel;
    @(posedge clk) disable iff (sys_rst)
    (loaded && pins_s.prog) ##1 (loaded && $stable(pins_s.prog))
      |-> (clock_in_sel == ctrl_q[`CFO_SEL_BIT]);
  endproperty
  a_prog_sel: assert property (p_prog_sel) else $error("select not from bit 10");

  property p_prog_oe;
    @(posedge clk) disable iff (sys_rst)
    (loaded && pins_s.prog) ##1 (loaded && pins_s.prog)
      |-> (pair_oe_n[0] == ~ctrl_q[PAIRS-1] && pair_oe_n[PAIRS-1] == ~ctrl_q[0]);
  endproperty
  a_prog_oe: assert property (p_prog_oe) else $error("pair enable mismatch");
endmodule // cfo_fanout_ctrl

//--- verif/cfo_ctl_model.sv
/*
  Controller model that drives the three configuration pins.
  Assumes the block samples these pins with its own clock.
*/
module cfo_ctl_model (
  output logic sck,  // shift clock pin
  output logic sdi,  // serial-in pin
  output logic prog  // program-mode pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // open pins: pull-up on shift clock, pull-downs on the others
  initial
  begin
    sck  = 1'h1;
    sdi  = 1'h0;
    prog = 1'h0;
  end

  // one 125 ns shift-clock period; data is set while the clock is low
  // data is released mid-way through the high phase so no pin is written twice in one step
  task automatic pulse(input logic s, input logic p);
    sdi  <= s;
    prog <= p;
    sck  <= 1'h0;
    #62.5;
    sck  <= 1'h1;
    #30;
    sdi  <= 1'h0; // released line falls to its pull-down
    #32.5;
  endtask

  // static levels on serial-in and program mode; the shift clock stays idle high
  task automatic hold_level(input logic s, input logic p);
    sdi  <= s;
    prog <= p;
  endtask
endmodule // cfo_ctl_model

//--- verif/clock_fanout_serial_config_tb.sv
/*
  Self-checking bench for the fan-out configuration block.
  Assumes cfo_ctl_model drives the pins and the clock runs at 100 MHz.
*/
module clock_fanout_serial_config_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        sys_rst;
  logic        sck;
  logic        sdi;
  logic        prog;
  logic [9:0]  pair_oe_n;
  logic        clock_in_sel;
  logic        ctrl_loaded;
  logic [10:0] ctrl_word;
  int          n_fail;
  int          n_checks;

  cfo_fanout_ctrl u_cfo_fanout_ctrl (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .config_shift_clock (sck),
    .config_serial_in   (sdi),
    .config_prog_mode   (prog),
    .pair_oe_n          (pair_oe_n),
    .clock_in_sel       (clock_in_sel),
    .ctrl_loaded        (ctrl_loaded),
    .ctrl_word          (ctrl_word)
  );

  cfo_ctl_model u_cfo_ctl_model (
    .sck  (sck),
    .sdi  (sdi),
    .prog (prog)
  );

  // 100 MHz system clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // outputs land at most four edges after a pin change; eight leaves margin
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  task automatic look(input logic [9:0] oe_n, input logic sel, input logic ld);
    chk("pair_oe_n", {1'h0, pair_oe_n}, {1'h0, oe_n});
    chk("clock_in_sel", {10'h000, clock_in_sel}, {10'h000, sel});
    chk("ctrl_loaded", {10'h000, ctrl_loaded}, {10'h000, ld});
  endtask

  // first bit shifted drives pair nine; a one enables, so oe_n is inverted
  function automatic logic [9:0] exp_oe(input logic [10:0] w);
    logic [9:0] r;
    for (int i = 0; i < 10; i++)
      r[9 - i] = ~w[i];
    return r;
  endfunction

  task automatic t_standard;
    u_cfo_ctl_model.hold_level(1'h1, 1'h0);
    settle();
    look(10'h000, 1'h1, 1'h0);
    u_cfo_ctl_model.hold_level(1'h0, 1'h0);
    settle();
    look(10'h000, 1'h0, 1'h0);
  endtask

  // rearm, shift eleven bits, check nothing loaded yet, then load
  task automatic t_program(input logic [10:0] w);
    u_cfo_ctl_model.pulse(1'h0, 1'h0);
    for (int i = 0; i < 11; i++)
      u_cfo_ctl_model.pulse(w[i], 1'h1);
    settle();
    look(10'h000, 1'h0, 1'h0);
    chk("ctrl_word", ctrl_word, 11'h000);
    u_cfo_ctl_model.pulse(1'h0, 1'h1);
    settle();
    look(exp_oe(w), w[10], 1'h1);
    chk("ctrl_word", ctrl_word, w);
  endtask

  // a second word without rearm must leave the first one in force
  task automatic t_ignore(input logic [10:0] w);
    for (int i = 0; i < 12; i++)
      u_cfo_ctl_model.pulse(~w[i % 11], 1'h1);
    settle();
    look(exp_oe(w), w[10], 1'h1);
    chk("ctrl_word", ctrl_word, w);
  endtask

  // standard mode overrides a loaded word, raising prog reuses it, a low-mode pulse clears it
  task automatic t_rearm(input logic [10:0] w);
    u_cfo_ctl_model.hold_level(1'h1, 1'h0);
    settle();
    look(10'h000, 1'h1, 1'h1);
    u_cfo_ctl_model.hold_level(1'h1, 1'h1);
    settle();
    look(exp_oe(w), w[10], 1'h1);
    chk("ctrl_word", ctrl_word, w);
    u_cfo_ctl_model.pulse(1'h0, 1'h0);
    settle();
    look(10'h000, 1'h0, 1'h0);
    chk("ctrl_word", ctrl_word, 11'h000);
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    #50us;
    n_fail++;
    $display("[ERR] watchdog expired");
    summarize();
  end

  initial
  begin
    n_fail = 0;
    n_checks = 0;
    sys_rst = 1'h1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    settle();
    look(10'h000, 1'h0, 1'h0);
    t_standard();
    t_program(11'h2c3);
    t_ignore(11'h2c3);
    t_rearm(11'h2c3);
    t_program(11'h6b1);
    summarize();
  end
endmodule // clock_fanout_serial_config_tb
